// >>> pci_host_model.sv
// Host bus master model: single data phase transfers with retry and abort detection
`timescale 1ns/10ps
module pci_host_model (
	input  wire logic        clk_sys,
	input  wire logic        trdy_n,
	input  wire logic        stop_n,
	input  wire logic        devsel_n,
	input  wire logic [31:0] ad_w,
	output logic             frame_n,
	output logic             irdy_n,
	output logic             idsel,
	output logic [3:0]       cbe_n,
	output logic [31:0]      ad,
	output logic             done,
	output logic [63:0]      res
);
	// Idle bus at time zero
	initial begin
		frame_n = 1'b1;
		irdy_n = 1'b1;
		idsel = 1'b0;
		cbe_n = 4'hf;
		ad = 32'h0000_0000;
		done = 1'b0;
		res = 64'h0000_0000_0000_0000;
	end

	// Result code: 0 data, 1 retry, 2 no claim, 3 hung
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, input logic [3:0] be,
		input logic [31:0] wd, input logic sel);
		int n;
		logic [1:0] k;
		n = 0;
		k = 2'd3;
		@(posedge clk_sys);
		#1;
		frame_n = 1'b0;
		idsel = sel;
		cbe_n = cmd;
		ad = a;
		@(posedge clk_sys);
		#1;
		frame_n = 1'b1;
		irdy_n = 1'b0;
		idsel = 1'b0;
		cbe_n = ~be;
		ad = cmd[0] ? wd : ~a; // Released on reads: inverse pattern, not a stale value
		while (n < 20 && k == 2'd3) begin
			@(posedge clk_sys);
			n++;
			if (!trdy_n)
				k = 2'd0;
			else if (!stop_n)
				k = 2'd1;
			else if (devsel_n && n > 4)
				k = 2'd2;
		end
		res = {22'h0, k, n[7:0], (k == 2'd0) ? ad_w : 32'h0000_0000};
		#1;
		irdy_n = 1'b1;
		cbe_n = 4'hf;
		ad = ~ad;
		done = 1'b1;
		@(posedge clk_sys);
		#1;
		done = 1'b0;
		@(posedge clk_sys);
		#1; // Caller changes its inputs off the edge
	endtask
endmodule

// >>> pci_target_trigger_port.sv
// Bus target for the analog input board: window decode, mailbox, interrupt, trigger
// Notes on behaviour
// [RULE1] Input trigger: start conversion on falling edge
// [RULE2] External trigger low pulse at least 500 ns
// [RULE3] Output trigger pulse low at most 500 ns
// [RULE4] One base register claims a 4K window
// [RULE5] Config and memory commands, byte lane enables
// [RULE6] Interrupt per channel or per group
// [RULE7] Register accesses finish in eight bus clocks
// [RULE8] Mailbox read colliding with write gets retry
// [RULE9] Master repeats a retried mailbox read later
// [RULE10] Converter mailbox write always wins
`timescale 1ns/10ps
`include "trig_pci_cfg.svh"
module pci_target_trigger_port #(
	parameter logic [15:0] VENDOR_ID  = 16'h5a5a, // Arbitrary value
	parameter logic [15:0] DEVICE_ID  = 16'h0001, // Arbitrary value
	parameter logic [31:0] CLASS_REV  = 32'h1180_0000 // Arbitrary value
) (
	input  wire logic                    clk_sys,
	input  wire logic                    arst_n,
	input  wire logic [31:0]             ad_i,
	output logic [31:0]                  ad_o,
	output logic                         ad_oe_n,
	input  wire logic [3:0]              cbe_n,
	input  wire logic                    frame_n,
	input  wire logic                    irdy_n,
	input  wire logic                    idsel,
	output logic                         trdy_n,
	output logic                         devsel_n,
	output logic                         stop_n,
	output logic                         ctl_oe_n,
	output logic                         par_o,
	output logic                         par_oe_n,
	output logic                         inta_o,
	output logic                         inta_oe_n,
	input  wire logic                    trig_i,
	output logic                         trig_o,
	output logic                         trig_oe_n,
	output logic                         conv_start,
	input  wire logic                    trig_dir_out,
	input  wire logic                    trig_fire,
	input  wire logic                    group_mode,
	input  wire logic                    conv_done,
	input  wire logic                    group_done,
	input  wire logic                    irq_clear,
	input  wire trig_pci_pkg::mbox_wr_s  mbox_wr,
	output trig_pci_pkg::reg_req_s       reg_req,
	input  wire logic [31:0]             reg_rdata
);
	trig_pci_pkg::tgt_state_e state;
	logic        rst_q1;
	logic        rst_n;
	logic        frame_q;
	logic [3:0]  cnt;
	logic        is_cfg;
	logic        is_rd;
	logic        is_mbox;
	logic        retry_q;
	logic [9:0]  addr_q;
	logic        mem_en;
	logic        int_dis;
	logic [19:0] bar;
	logic [7:0]  int_line;
	logic        irq_pend;
	logic [31:0] mbox_mem [0:(1 << `MBOX_AW) - 1];
	logic [31:0] cfg_rdata;
	logic        hit_cfg;
	logic        hit_mem;
	logic        start;
	logic        wr_go;
	logic        rd_load;

	// Reset released through two flops
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	// Address phase decode; bus pins share this clock so no sampler is needed
	assign hit_cfg = idsel && ad_i[1:0] == 2'b00
		&& (cbe_n == `CMD_CFG_RD || cbe_n == `CMD_CFG_WR); // see [RULE5]
	assign hit_mem = mem_en && ad_i[31:`WIN_BITS] == bar
		&& (cbe_n == `CMD_MEM_RD || cbe_n == `CMD_MEM_WR); // see [RULE4]
	assign start   = state == trig_pci_pkg::ST_IDLE && !frame_n && frame_q
		&& (hit_cfg || hit_mem);
	assign wr_go   = state == trig_pci_pkg::ST_XFER && !irdy_n && !is_rd;
	assign rd_load = state == trig_pci_pkg::ST_WAIT && cnt == 4'(`ACC_CYCLES - 4);

	// Bus handshake; every data phase ends in a disconnect so bursts stay single
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state    <= trig_pci_pkg::ST_IDLE;
			frame_q  <= 1'b1;
			cnt      <= 4'h0;
			is_cfg   <= 1'b0;
			is_rd    <= 1'b0;
			is_mbox  <= 1'b0;
			addr_q   <= 10'h000;
			trdy_n   <= 1'b1;
			devsel_n <= 1'b1;
			stop_n   <= 1'b1;
			ctl_oe_n <= 1'b1;
			ad_oe_n  <= 1'b1;
		end else begin
			frame_q <= frame_n;
			case (state)
				trig_pci_pkg::ST_IDLE: begin
					ctl_oe_n <= 1'b1;
					if (start) begin
						state    <= trig_pci_pkg::ST_WAIT;
						cnt      <= 4'h0;
						is_cfg   <= hit_cfg;
						is_rd    <= !cbe_n[0];
						is_mbox  <= hit_mem && ad_i[`MBOX_SEL_BIT];
						addr_q   <= ad_i[11:2];
						devsel_n <= 1'b0;
						ctl_oe_n <= 1'b0;
					end
				end
				trig_pci_pkg::ST_WAIT: begin
					cnt <= cnt + 4'h1;
					if (cnt == 4'h0)
						ad_oe_n <= !is_rd; // Turnaround cycle before driving
					if (cnt == 4'(`ACC_CYCLES - 3)) begin
						stop_n <= 1'b0;
						if (retry_q)
							state <= trig_pci_pkg::ST_RETRY; // see [RULE8]
						else begin
							trdy_n <= 1'b0; // see [RULE7]
							state  <= trig_pci_pkg::ST_XFER;
						end
					end
				end
				trig_pci_pkg::ST_XFER, trig_pci_pkg::ST_RETRY: begin
					if (!irdy_n) begin
						state    <= trig_pci_pkg::ST_TURN;
						trdy_n   <= 1'b1;
						stop_n   <= 1'b1;
						devsel_n <= 1'b1;
						ad_oe_n  <= 1'b1;
					end
				end
				trig_pci_pkg::ST_TURN: begin
					ctl_oe_n <= 1'b1;
					state    <= trig_pci_pkg::ST_IDLE;
				end
				default: state <= trig_pci_pkg::ST_IDLE;
			endcase
		end
	end

	// Collision is judged on the read cycle; master must come back, see [RULE9]
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			retry_q <= 1'b0;
		else if (start)
			retry_q <= 1'b0;
		else if (rd_load)
			retry_q <= is_rd && is_mbox && mbox_wr.en; // see [RULE8]
	end

	// Converter write port owns the array; bus writes never touch it
	always_ff @(posedge clk_sys) begin
		if (mbox_wr.en)
			mbox_mem[mbox_wr.addr] <= mbox_wr.data; // see [RULE10]
	end

	// Config space read view; unlisted dwords read zero
	always_comb begin
		case (addr_q[5:0])
			`CFG_ID:       cfg_rdata = {DEVICE_ID, VENDOR_ID};
			`CFG_CMD_STAT: cfg_rdata = {12'h000, irq_pend, 8'h00, int_dis, 8'h00,
				mem_en, 1'b0};
			`CFG_CLASS:    cfg_rdata = CLASS_REV;
			`CFG_BAR0:     cfg_rdata = {bar, 12'h000}; // see [RULE4]
			`CFG_INTR:     cfg_rdata = {16'h0000, `INT_PIN_A, int_line};
			default:       cfg_rdata = 32'h0000_0000;
		endcase
	end

	// Read data is loaded once, one cycle before trdy_n is driven low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ad_o <= 32'h0000_0000;
		else if (rd_load && is_rd) begin
			if (is_cfg)
				ad_o <= cfg_rdata;
			else if (is_mbox)
				ad_o <= mbox_mem[addr_q[8:0]];
			else
				ad_o <= reg_rdata;
		end
	end

	// Parity follows the driven data by one clock
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			par_o    <= 1'b0;
			par_oe_n <= 1'b1;
		end else begin
			par_o    <= ^{ad_o, cbe_n};
			par_oe_n <= ad_oe_n;
		end
	end

	// Config writes honour each byte lane separately
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_en   <= 1'b0;
			int_dis  <= 1'b0;
			bar      <= 20'h0_0000;
			int_line <= 8'h00;
		end else if (wr_go && is_cfg) begin
			if (addr_q[5:0] == `CFG_CMD_STAT && !cbe_n[0])
				mem_en <= ad_i[`CMD_MEM_EN]; // see [RULE5]
			if (addr_q[5:0] == `CFG_CMD_STAT && !cbe_n[1])
				int_dis <= ad_i[`CMD_INT_DIS];
			if (addr_q[5:0] == `CFG_BAR0 && !cbe_n[1])
				bar[3:0] <= ad_i[15:12];
			if (addr_q[5:0] == `CFG_BAR0 && !cbe_n[2])
				bar[11:4] <= ad_i[23:16];
			if (addr_q[5:0] == `CFG_BAR0 && !cbe_n[3])
				bar[19:12] <= ad_i[31:24];
			if (addr_q[5:0] == `CFG_INTR && !cbe_n[0])
				int_line <= ad_i[7:0];
		end
	end

	// Window accesses outside the mailbox go to the board registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			reg_req <= '0;
		else begin
			reg_req.rd <= rd_load == 1'b0 && state == trig_pci_pkg::ST_WAIT
				&& cnt == 4'h0 && is_rd && !is_cfg && !is_mbox;
			reg_req.wr <= wr_go && !is_cfg && !is_mbox;
			if (start)
				reg_req.addr <= ad_i[11:2];
			if (wr_go) begin
				reg_req.be    <= ~cbe_n; // see [RULE5]
				reg_req.wdata <= ad_i;
			end
		end
	end

	// Sticky request; a new event beats a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_pend  <= 1'b0;
			inta_oe_n <= 1'b1;
			inta_o    <= 1'b0;
		end else begin
			irq_pend  <= (group_mode ? group_done : conv_done) // see [RULE6]
				|| (irq_pend && !irq_clear);
			inta_oe_n <= !(irq_pend && !int_dis);
		end
	end

	trig_pin_ctrl u_trig (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.trig_i     (trig_i),
		.dir_out    (trig_dir_out),
		.fire       (trig_fire),
		.trig_o     (trig_o),
		.trig_oe_n  (trig_oe_n),
		.conv_start (conv_start)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_access_eight_clk: assert property (start |-> ##7 !stop_n && !devsel_n) // see [RULE7]
		else $error("access not answered on eighth clock");
	a_ready_not_retry: assert property (start |-> ##7 (trdy_n == retry_q)) // see [RULE7]
		else $error("ready and retry disagree");
	a_retry_no_data: assert property (state == trig_pci_pkg::ST_RETRY |-> trdy_n) // see [RULE8]
		else $error("data offered on retry");
	a_retry_cause: assert property ($rose(retry_q) |-> $past(mbox_wr.en) && is_mbox) // see [RULE8]
		else $error("retry without collision");
	a_mbox_write_wins: assert property (mbox_wr.en |=> // see [RULE10]
		mbox_mem[$past(mbox_wr.addr)] == $past(mbox_wr.data))
		else $error("converter write lost");
	a_window_decode: assert property (start && !idsel |-> ad_i[31:12] == bar && mem_en) // see [RULE4]
		else $error("claimed outside window");
	a_byte_lane_keep: assert property (wr_go && is_cfg && cbe_n[0] |=> $stable(mem_en)) // see [RULE5]
		else $error("disabled lane written");
	a_irq_mode: assert property (!group_mode && conv_done ##1 !int_dis |=> !inta_oe_n) // see [RULE6]
		else $error("channel interrupt missing");
	a_irq_group_only: assert property (group_mode && !group_done && !irq_pend |=> !irq_pend) // see [RULE6]
		else $error("group interrupt raised early");
	c_read_ok: cover property (state == trig_pci_pkg::ST_XFER && !irdy_n && is_rd);
	c_retry: cover property (state == trig_pci_pkg::ST_RETRY && !irdy_n);
	c_irq: cover property ($fell(inta_oe_n));
endmodule

// >>> test_pci_target_trigger_port.sv
// Self-checking bench for the bus target, interrupt and trigger pin
`timescale 1ns/10ps
`include "trig_pci_cfg.svh"
module test_pci_target_trigger_port;
	localparam logic [15:0] VID  = 16'h3c3c; // Arbitrary value
	localparam logic [15:0] DID  = 16'h0042; // Arbitrary value
	localparam logic [31:0] BASE = 32'h4000_0000;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [31:0] ad_w, m_ad, ad_o, reg_rdata, lf, md;
	logic [3:0] cbe_n;
	logic frame_n, irdy_n, idsel, trdy_n, devsel_n, stop_n, ad_oe_n, done;
	logic inta_oe_n, trig_o, trig_oe_n, conv_start, ext_trig, trig_w;
	logic trig_dir_out, trig_fire, group_mode;
	logic [2:0] ev;
	logic [63:0] q[$];
	logic [63:0] res;
	trig_pci_pkg::mbox_wr_s mbox_wr;
	trig_pci_pkg::reg_req_s reg_req;
	int n_fail = 0;
	int checked = 0;
	int c;
	int n_rd = 0;
	logic ctl_oe_n, par_o, par_oe_n, inta_o, inta_w;
	logic p_par = 1'b0;
	logic [3:0] lanes [3] = '{4'h2, 4'hc, 4'hf};

	always #20 clk_sys = ~clk_sys;
	// Wire levels: target drives when enabled, trigger pin follows ext_trig when released
	assign ad_w = ad_oe_n ? m_ad : ad_o;
	assign trig_w = trig_oe_n ? ext_trig : trig_o;
	assign inta_w = inta_oe_n ? 1'b1 : inta_o; // Request line pulled up when released

	pci_target_trigger_port #(.VENDOR_ID(VID), .DEVICE_ID(DID)) dut_u (
		.clk_sys(clk_sys), .arst_n(arst_n), .ad_i(ad_w), .ad_o(ad_o), .ad_oe_n(ad_oe_n),
		.cbe_n(cbe_n), .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel), .trdy_n(trdy_n),
		.devsel_n(devsel_n), .stop_n(stop_n), .ctl_oe_n(ctl_oe_n), .par_o(par_o),
		.par_oe_n(par_oe_n), .inta_o(inta_o), .inta_oe_n(inta_oe_n), .trig_i(trig_w),
		.trig_o(trig_o),
		.trig_oe_n(trig_oe_n), .conv_start(conv_start), .trig_dir_out(trig_dir_out),
		.trig_fire(trig_fire), .group_mode(group_mode), .conv_done(ev[0]),
		.group_done(ev[1]), .irq_clear(ev[2]), .mbox_wr(mbox_wr), .reg_req(reg_req),
		.reg_rdata(reg_rdata));

	pci_host_model m_u (
		.clk_sys(clk_sys), .trdy_n(trdy_n), .stop_n(stop_n), .devsel_n(devsel_n),
		.ad_w(ad_w), .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel), .cbe_n(cbe_n),
		.ad(m_ad), .done(done), .res(res));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Notes the outcome first, plus the board write it should cause
	task automatic bus(input logic [3:0] cmd, input logic [31:0] a, input logic [3:0] be,
		input logic [31:0] d, input logic sel, input logic [1:0] k, input logic rq);
		q.push_back({22'h0, k, (k == 2'd2) ? 8'd5 : 8'd7, (k == 2'd0) ? d : 32'h0});
		if (rq)
			q.push_back({18'h0, a[11:2], be, d});
		m_u.xfer(cmd, a, be, d, sel);
		if (res[41:40] == 2'd3) begin
			n_fail++;
			wrap_up();
		end
		chk("target released", 1, ctl_oe_n);
	endtask

	task automatic pls(input logic [2:0] b);
		@(posedge clk_sys);
		#1 ev = b;
		@(posedge clk_sys);
		#1 ev = 3'b000;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	// Results are matched to the oldest note as they appear
	always @(posedge clk_sys) begin
		if (done === 1'b1)
			chk("bus result", q.size() ? q.pop_front() : '1, res);
		if (reg_req.wr === 1'b1)
			chk("reg write", q.size() ? q.pop_front() : '1,
				{18'h0, reg_req.addr, reg_req.be, reg_req.wdata});
		// Even parity over the lanes and enables seen one clock earlier
		if (par_oe_n === 1'b0)
			chk("parity", p_par, par_o);
		n_rd += (reg_req.rd === 1'b1);
		p_par = ^{ad_w, cbe_n};
	end

	initial begin
		{trig_dir_out, trig_fire, group_mode, ev} = 6'h00;
		ext_trig = 1'b1;
		mbox_wr = '0;
		reg_rdata = 32'h0000_0000;
		lf = 32'h0000_723e;
		repeat (8) @(posedge clk_sys);
		#1 arst_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		// Base register sizing, then placement and memory enable
		bus(`CMD_CFG_WR, 32'h10, 4'hf, 32'hffff_ffff, 1'b1, 2'd0, 1'b0);
		bus(`CMD_CFG_RD, 32'h10, 4'hf, 32'hffff_f000, 1'b1, 2'd0, 1'b0);
		bus(`CMD_CFG_WR, 32'h10, 4'hf, BASE, 1'b1, 2'd0, 1'b0);
		bus(`CMD_CFG_WR, 32'h04, 4'hf, 32'h0000_0002, 1'b1, 2'd0, 1'b0);
		// Lane one only: the enable in lane zero must survive a zero write
		bus(`CMD_CFG_WR, 32'h04, 4'h2, 32'h0000_0000, 1'b1, 2'd0, 1'b0);
		bus(`CMD_CFG_RD, 32'h04, 4'hf, 32'h0000_0002, 1'b1, 2'd0, 1'b0);
		bus(`CMD_CFG_RD, 32'h00, 4'hf, {DID, VID}, 1'b1, 2'd0, 1'b0);
		lf = lfsr(lf);
		reg_rdata = lf;
		bus(`CMD_MEM_RD, BASE | 32'h10, 4'hf, lf, 1'b0, 2'd0, 1'b0);
		// Byte, half word and word lanes
		foreach (lanes[i]) begin
			lf = lfsr(lf);
			bus(`CMD_MEM_WR, BASE | 32'h20, lanes[i], lf, 1'b0, 2'd0, 1'b1);
		end
		// Mailbox: plain read, bus write ignored, collision retry, repeat read; then a read outside the window that nobody claims
		md = lfsr(lf);
		mbox_wr = '{en: 1'b1, addr: 9'd3, data: md};
		@(posedge clk_sys);
		#1 mbox_wr.en = 1'b0;
		bus(`CMD_MEM_RD, BASE | 32'h80c, 4'hf, md, 1'b0, 2'd0, 1'b0);
		bus(`CMD_MEM_WR, BASE | 32'h80c, 4'hf, ~md, 1'b0, 2'd0, 1'b0);
		bus(`CMD_MEM_RD, BASE | 32'h80c, 4'hf, md, 1'b0, 2'd0, 1'b0);
		lf = lfsr(md);
		mbox_wr = '{en: 1'b1, addr: 9'd3, data: lf};
		bus(`CMD_MEM_RD, BASE | 32'h80c, 4'hf, lf, 1'b0, 2'd1, 1'b0);
		mbox_wr.en = 1'b0;
		bus(`CMD_MEM_RD, BASE | 32'h80c, 4'hf, lf, 1'b0, 2'd0, 1'b0);
		bus(`CMD_MEM_RD, 32'h8000_0000, 4'hf, 32'h0, 1'b0, 2'd2, 1'b0);
		// Interrupt line follows only the selected event, then clears
		for (int m = 0; m < 2; m++) begin
			group_mode = m[0];
			pls(3'b011 ^ (3'b001 << m));
			chk("irq other event", 1, inta_w);
			pls(3'b001 << m);
			chk("irq raised", 0, inta_w);
			pls(3'b100);
			chk("irq cleared", 1, inta_w);
		end
		// Input trigger: low for 13 clocks (520 ns) starts exactly one conversion
		c = 0;
		ext_trig = 1'b0;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			#1;
			if (i == 12)
				ext_trig = 1'b1;
			c += (conv_start === 1'b1);
		end
		chk("conv starts", 1, c);
		// Output trigger: pin low no longer than 500 ns, and no start from it
		trig_dir_out = 1'b1;
		trig_fire = 1'b1;
		@(posedge clk_sys);
		#1 trig_fire = 1'b0;
		c = 0;
		repeat (20) begin
			c += (trig_w === 1'b0) + ((conv_start === 1'b1) ? 100 : 0);
			@(posedge clk_sys);
			#1;
		end
		chk("trigger low clocks", `TRIG_LOW_NS / `CLK_NS, c);
		// Only the one plain register read may reach the board logic
		chk("reg reads", 1, n_rd);
		wrap_up();
	end
endmodule

// >>> trig_pci_cfg.svh
// Offsets, field positions, command codes and timing counts of the target port
`ifndef TRIG_PCI_CFG_SVH
`define TRIG_PCI_CFG_SVH
`define CLK_NS        40
`define ACC_CYCLES    8
`define TRIG_LOW_NS   500
`define TRIG_MIN_NS   500
`define WIN_BITS      12
`define MBOX_SEL_BIT  11
`define MBOX_AW       9
`define CMD_MEM_RD    4'h6
`define CMD_MEM_WR    4'h7
`define CMD_CFG_RD    4'ha
`define CMD_CFG_WR    4'hb
`define CFG_ID        6'h00
`define CFG_CMD_STAT  6'h01
`define CFG_CLASS     6'h02
`define CFG_BAR0      6'h04
`define CFG_INTR      6'h0f
`define CMD_MEM_EN    1
`define CMD_INT_DIS   10
`define STAT_INT      19
`define INT_PIN_A     8'h01
`endif

// >>> trig_pci_pkg.sv
// Types shared by the target port and its test bench
package trig_pci_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_XFER, ST_RETRY, ST_TURN} tgt_state_e;

	// Converter side write into the result mailbox
	typedef struct packed {
		logic        en;
		logic [8:0]  addr;
		logic [31:0] data;
	} mbox_wr_s;

	// Register access handed to the board logic behind the window
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [9:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} reg_req_s;
endpackage

// >>> trig_pin_ctrl.sv
// External trigger pin: falling edge detect as input, short low pulse as output
`timescale 1ns/10ps
`include "trig_pci_cfg.svh"
module trig_pin_ctrl (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic trig_i,
	input  wire logic dir_out,
	input  wire logic fire,
	output logic      trig_o,
	output logic      trig_oe_n,
	output logic      conv_start
);
	// Longest low time rounds down: 500 ns at 40 ns gives 12 cycles
	localparam logic [3:0] PW = 4'(`TRIG_LOW_NS / `CLK_NS);
	localparam int PW_I = `TRIG_LOW_NS / `CLK_NS;

	logic       s1;
	logic       s2;
	logic       s3;
	logic       lvl;
	logic [3:0] cnt;

	// Three stage sampler; a level only counts once stages two and three agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1  <= 1'b1;
			s2  <= 1'b1;
			s3  <= 1'b1;
			lvl <= 1'b1;
		end else begin
			s1 <= trig_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				lvl <= s2; // Source keeps low long enough to pass, see [RULE2]
		end
	end

	// Active low input: one start per high to low change
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			conv_start <= 1'b0;
		else
			conv_start <= !dir_out && lvl && (s2 == s3) && !s2; // see [RULE1]
	end

	// Output pulse; a fire during a pulse is dropped so width never stretches
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt       <= 4'h0;
			trig_oe_n <= 1'b1;
			trig_o    <= 1'b0;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
			if (cnt == 4'h1)
				trig_oe_n <= 1'b1; // see [RULE3]
		end else if (fire && dir_out) begin
			cnt       <= PW;
			trig_oe_n <= 1'b0; // see [RULE3]
		end
	end

	a_trig_low_max: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE3]
		$fell(trig_oe_n) |-> ##PW_I trig_oe_n)
		else $error("trigger pulse width wrong");
	a_trig_start_edge: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE1]
		(!dir_out && lvl && s2 == s3 && !s2) |=> conv_start)
		else $error("falling trigger edge missed");
	a_trig_no_start: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE1]
		conv_start |-> $past(!dir_out) && !lvl)
		else $error("start without falling edge");
	c_trig_in: cover property (@(posedge clk_sys) disable iff (!rst_n) conv_start);
	c_trig_out: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(trig_oe_n));
endmodule
